/* File: hw/encoder_emulation_port.sv */
`default_nettype none

module encoder_emulation_port #(
    parameter int LPR_W = 16,
    parameter int SCALE_W = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [emu_port_pkg::MODE_W-1:0] emulation_function_select,
    input wire logic [LPR_W-1:0] emulation_lines_per_rev,
    input wire logic [emu_port_pkg::POS_W-1:0] index_fraction_offset,
    input wire logic [emu_port_pkg::POS_W-1:0] absolute_turn_offset,
    input wire logic emulation_direction_invert,
    input wire logic [emu_port_pkg::FMT_W-1:0] secondary_input_format,
    input wire logic [SCALE_W-1:0] step_scale,
    input wire emu_port_pkg::pos_t motor_position,
    input wire logic emu_a_in,
    input wire logic emu_b_in,
    output emu_port_pkg::quad_t emulated_encoder_output,
    output logic emu_oe,
    input wire logic opto_step_in,
    input wire logic opto_dir_in,
    output emu_port_pkg::pos_t full_offset,
    output emu_port_pkg::cmd_t command_position,
    output logic command_step,
    output logic command_active
);

    localparam int PW = emu_port_pkg::POS_W;

    if (LPR_W > PW || LPR_W < 2 || SCALE_W > PW || SCALE_W < 1) begin : g_check
        $error("encoder_emulation_port: unsupported LPR_W or SCALE_W");
    end

    // Mode decode
    logic out_mode;
    logic abs_index;
    logic in_en;
    logic [emu_port_pkg::FMT_W-1:0] in_fmt;
    logic [1:0] in_pins;
    logic lpr_zero;
    logic [PW-1:0] lpr;

    always_comb begin
        lpr = PW'(emulation_lines_per_rev);
        lpr_zero = (emulation_lines_per_rev == '0);
        out_mode = 1'b0;
        abs_index = 1'b0;
        in_en = 1'b0;
        in_fmt = emu_port_pkg::FMT_QUAD;
        in_pins = {emu_b_in, emu_a_in};
        unique case (emulation_function_select)
            emu_port_pkg::MODE_INPUT: begin
                in_en = 1'b1;
                in_fmt = secondary_input_format;
            end
            emu_port_pkg::MODE_OUT_REV: begin
                out_mode = 1'b1;
            end
            emu_port_pkg::MODE_OUT_ABS: begin
                out_mode = 1'b1;
                abs_index = 1'b1;
            end
            emu_port_pkg::MODE_IN_QUAD: begin
                in_en = 1'b1;
                in_fmt = emu_port_pkg::FMT_QUAD;
            end
            emu_port_pkg::MODE_IN_STEP: begin
                in_en = 1'b1;
                in_fmt = emu_port_pkg::FMT_STEP;
            end
            emu_port_pkg::MODE_IN_UPDN: begin
                in_en = 1'b1;
                in_fmt = emu_port_pkg::FMT_UPDN;
            end
            emu_port_pkg::MODE_OUT_REV_STEP, emu_port_pkg::MODE_OUT_ABS_STEP: begin
                out_mode = 1'b1;
                abs_index = (emulation_function_select == emu_port_pkg::MODE_OUT_ABS_STEP);
                in_en = 1'b1;
                in_fmt = emu_port_pkg::FMT_STEP;
                in_pins = {opto_dir_in, opto_step_in};
            end
        endcase
    end

    // Edge pacing enable
    logic [emu_port_pkg::PACE_W-1:0] pace_r;
    logic [emu_port_pkg::PACE_W-1:0] pace_nxt;
    logic tick;

    always_comb begin
        tick = (pace_r == '0);
        pace_nxt = tick ? emu_port_pkg::PACE_W'(emu_port_pkg::EDGE_SPACING_CYC - 1)
                        : emu_port_pkg::PACE_W'(pace_r - 1'b1);
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pace_r <= '0;
        end else begin
            pace_r <= pace_nxt;
        end
    end

    // Target count within revolution
    logic [2*PW-1:0] tgt_prod;
    logic [2*PW-1:0] idx_prod;
    logic [PW-1:0] tgt_cnt_r;
    logic [PW-1:0] tgt_turn_r;
    logic [PW-1:0] tgt_cnt_nxt;
    logic [PW-1:0] zcnt;

    always_comb begin
        tgt_prod = (2*PW)'(motor_position.frac) * (2*PW)'(lpr);
        tgt_cnt_nxt = tgt_prod[2*PW-1:emu_port_pkg::FRAC_SHIFT];
        idx_prod = (2*PW)'(index_fraction_offset) * (2*PW)'(lpr);
        zcnt = idx_prod[2*PW-1:emu_port_pkg::FRAC_SHIFT];
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tgt_cnt_r <= emu_port_pkg::RST_POS;
            tgt_turn_r <= emu_port_pkg::RST_POS;
        end else begin
            tgt_cnt_r <= tgt_cnt_nxt;
            tgt_turn_r <= motor_position.turn;
        end
    end

    // Emitted position tracker
    logic [PW-1:0] emit_cnt_r;
    logic [PW-1:0] emit_cnt_nxt;
    logic [PW-1:0] emit_turn_r;
    logic [PW-1:0] emit_turn_nxt;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic [PW-1:0] turn_diff;
    logic behind;
    logic fwd;
    emu_port_pkg::quad_t quad_nxt;
    logic oe_nxt;

    always_comb begin
        emit_cnt_nxt = emit_cnt_r;
        emit_turn_nxt = emit_turn_r;
        phase_nxt = phase_r;
        turn_diff = PW'(tgt_turn_r - emit_turn_r);
        behind = (turn_diff != '0) || (tgt_cnt_r != emit_cnt_r);
        fwd = (turn_diff != '0) ? ~turn_diff[PW-1] : (tgt_cnt_r > emit_cnt_r);
        if (!out_mode || lpr_zero) begin
            emit_cnt_nxt = tgt_cnt_r;
            emit_turn_nxt = tgt_turn_r;
        end else if (tick && behind) begin
            if (fwd) begin
                phase_nxt = 2'(phase_r + 2'h1);
                if (emit_cnt_r == PW'(lpr - 1'b1)) begin
                    emit_cnt_nxt = '0;
                    emit_turn_nxt = PW'(emit_turn_r + 1'b1);
                end else begin
                    emit_cnt_nxt = PW'(emit_cnt_r + 1'b1);
                end
            end else begin
                phase_nxt = 2'(phase_r - 2'h1);
                if (emit_cnt_r == '0) begin
                    emit_cnt_nxt = PW'(lpr - 1'b1);
                    emit_turn_nxt = PW'(emit_turn_r - 1'b1);
                end else begin
                    emit_cnt_nxt = PW'(emit_cnt_r - 1'b1);
                end
            end
        end
        quad_nxt.a = phase_nxt[0] ^ phase_nxt[1];
        quad_nxt.b = phase_nxt[1];
        if (emulation_direction_invert) begin
            quad_nxt.a = phase_nxt[1];
            quad_nxt.b = phase_nxt[0] ^ phase_nxt[1];
        end
        quad_nxt.z = out_mode && !lpr_zero && (emit_cnt_nxt == zcnt);
        if (abs_index && (emit_turn_nxt != absolute_turn_offset)) begin
            quad_nxt.z = 1'b0;
        end
        // drive connector only in output modes
        oe_nxt = out_mode;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            emit_cnt_r <= emu_port_pkg::RST_POS;
            emit_turn_r <= emu_port_pkg::RST_POS;
            phase_r <= emu_port_pkg::RST_PHASE;
            emulated_encoder_output <= '0;
            emu_oe <= 1'b0;
        end else begin
            emit_cnt_r <= emit_cnt_nxt;
            emit_turn_r <= emit_turn_nxt;
            phase_r <= phase_nxt;
            emulated_encoder_output <= quad_nxt;
            emu_oe <= oe_nxt;
        end
    end

    emu_port_pkg::pos_t full_offset_nxt;

    always_comb begin
        full_offset_nxt.turn = absolute_turn_offset;
        full_offset_nxt.frac = index_fraction_offset;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            full_offset <= '0;
        end else begin
            full_offset <= full_offset_nxt;
        end
    end

    // Input decode
    logic dec_up;
    logic dec_down;
    logic dec_en;

    assign dec_en = in_en && !lpr_zero;

    pulse_decoder u_decoder (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pins(in_pins),
        .format(in_fmt),
        .enable(dec_en),
        .up(dec_up),
        .down(dec_down)
    );

    // Command accumulator
    emu_port_pkg::cmd_t cmd_r;
    emu_port_pkg::cmd_t cmd_nxt;
    logic [PW-1:0] weight;
    logic [PW:0] sum;
    logic step_nxt;

    always_comb begin
        cmd_nxt = cmd_r;
        step_nxt = 1'b0;
        weight = PW'(1);
        if (in_fmt == emu_port_pkg::FMT_STEP && step_scale != '0) begin
            weight = PW'(step_scale);
        end
        if (weight > lpr && !lpr_zero) begin
            weight = lpr;
        end
        sum = (PW+1)'(cmd_r.count) + (PW+1)'(weight);
        if (!dec_en) begin
            cmd_nxt = cmd_r;
        end else if (dec_up) begin
            step_nxt = 1'b1;
            if (sum >= (PW+1)'(lpr)) begin
                cmd_nxt.count = PW'(sum - (PW+1)'(lpr));
                cmd_nxt.turn = PW'(cmd_r.turn + 1'b1);
            end else begin
                cmd_nxt.count = PW'(sum);
            end
        end else if (dec_down) begin
            step_nxt = 1'b1;
            if (cmd_r.count >= weight) begin
                cmd_nxt.count = PW'(cmd_r.count - weight);
            end else begin
                cmd_nxt.count = PW'(cmd_r.count + lpr - weight);
                cmd_nxt.turn = PW'(cmd_r.turn - 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cmd_r <= '0;
            command_step <= 1'b0;
            command_active <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            command_step <= step_nxt;
            command_active <= dec_en;
        end
    end

    assign command_position = cmd_r;

endmodule // encoder_emulation_port

`default_nettype wire

/* File: shared/emu_port_pkg.sv */
// Notes on behaviour
// - Select 0: connector input only, format from setting.
// - Output A, B, index; A/B in quadrature.
// - Exactly lines-per-rev counts per feedback revolution.
// - Lines-per-rev counts post-quadrature edges.
// - Select 1: index each revolution at fraction offset.
// - Fraction offset scaled 65536 per revolution.
// - Select 2: single index at turns plus fraction.
// - Full offset is a read-only derived value.
// - Select 3: quadrature input as command source.
// - Select 4: pulse/direction input with step scaling.
// - Select 5: up/down count inputs as command.
// - Select 6/7: output plus opto step/direction input.
// - Input: lines-per-rev received counts make one revolution.
// - Lines-per-rev zero: no command generated.
// - Format 0 quadrature, 1 step/dir, 2 up/down.
`default_nettype none

package emu_port_pkg;

    localparam int MODE_W = 3;
    localparam int FMT_W = 2;
    localparam int POS_W = 16;

    localparam logic [MODE_W-1:0] MODE_INPUT = 3'h0;
    localparam logic [MODE_W-1:0] MODE_OUT_REV = 3'h1;
    localparam logic [MODE_W-1:0] MODE_OUT_ABS = 3'h2;
    localparam logic [MODE_W-1:0] MODE_IN_QUAD = 3'h3;
    localparam logic [MODE_W-1:0] MODE_IN_STEP = 3'h4;
    localparam logic [MODE_W-1:0] MODE_IN_UPDN = 3'h5;
    localparam logic [MODE_W-1:0] MODE_OUT_REV_STEP = 3'h6;
    localparam logic [MODE_W-1:0] MODE_OUT_ABS_STEP = 3'h7;

    localparam logic [FMT_W-1:0] FMT_QUAD = 2'h0;
    localparam logic [FMT_W-1:0] FMT_STEP = 2'h1;
    localparam logic [FMT_W-1:0] FMT_UPDN = 2'h2;

    // Fraction scale: one revolution is 2**FRAC_SHIFT
    localparam int FRAC_SHIFT = 16;

    // Emulated edge pacing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int EDGE_SPACING_NS = 20;
    localparam int EDGE_SPACING_CYC = (EDGE_SPACING_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PACE_W = 8;

    localparam logic [POS_W-1:0] RST_POS = 16'h0000;
    localparam logic [1:0] RST_PHASE = 2'h0;
    localparam logic [1:0] RST_PINS = 2'h0;

    typedef struct packed {
        logic [POS_W-1:0] turn;
        logic [POS_W-1:0] frac;
    } pos_t;

    typedef struct packed {
        logic [POS_W-1:0] turn;
        logic [POS_W-1:0] count;
    } cmd_t;

    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } quad_t;

    // Quadrature phase index of {a, b}; forward is +1
    function automatic logic [1:0] quad_index(input logic a, input logic b);
        quad_index = {b, a ^ b};
    endfunction

endpackage

`default_nettype wire

/* File: hw/pulse_decoder.sv */
`default_nettype none

module pulse_decoder (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [1:0] pins,
    input wire logic [emu_port_pkg::FMT_W-1:0] format,
    input wire logic enable,
    output logic up,
    output logic down
);

    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] stable_r;
    logic [1:0] stable_nxt;
    logic up_nxt;
    logic down_nxt;
    logic [1:0] idx_old;
    logic [1:0] idx_new;
    logic rise_a;
    logic rise_b;

    always_comb begin
        // Change accepted once stages two and three agree
        stable_nxt = (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & stable_r);
        idx_old = emu_port_pkg::quad_index(stable_r[0], stable_r[1]);
        idx_new = emu_port_pkg::quad_index(stable_nxt[0], stable_nxt[1]);
        rise_a = stable_nxt[0] & ~stable_r[0];
        rise_b = stable_nxt[1] & ~stable_r[1];
        up_nxt = 1'b0;
        down_nxt = 1'b0;
        if (enable) begin
            unique case (format)
                emu_port_pkg::FMT_QUAD: begin
                    up_nxt = (idx_new == 2'(idx_old + 2'h1));
                    down_nxt = (idx_new == 2'(idx_old - 2'h1));
                end
                emu_port_pkg::FMT_STEP: begin
                    up_nxt = rise_a & stable_nxt[1];
                    down_nxt = rise_a & ~stable_nxt[1];
                end
                emu_port_pkg::FMT_UPDN: begin
                    up_nxt = rise_a & ~rise_b;
                    down_nxt = rise_b & ~rise_a;
                end
                default: begin
                    up_nxt = 1'b0;
                    down_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_r <= emu_port_pkg::RST_PINS;
            s2_r <= emu_port_pkg::RST_PINS;
            s3_r <= emu_port_pkg::RST_PINS;
            stable_r <= emu_port_pkg::RST_PINS;
            up <= 1'b0;
            down <= 1'b0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stable_r <= stable_nxt;
            up <= up_nxt;
            down <= down_nxt;
        end
    end

endmodule // pulse_decoder

`default_nettype wire

/* File: test/emu_port_props.sv */
`default_nettype none

module emu_port_props #(
    parameter int LPR_W = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [emu_port_pkg::MODE_W-1:0] emulation_function_select,
    input wire logic [LPR_W-1:0] emulation_lines_per_rev,
    input wire logic emulation_direction_invert,
    input wire logic [emu_port_pkg::FMT_W-1:0] secondary_input_format,
    input wire emu_port_pkg::quad_t emulated_encoder_output,
    input wire logic emu_oe,
    input wire emu_port_pkg::cmd_t command_position,
    input wire logic command_step,
    input wire logic command_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic a;
    logic b;
    logic z;
    logic out_mode;
    logic in_en;
    assign a = emulated_encoder_output.a;
    assign b = emulated_encoder_output.b;
    assign z = emulated_encoder_output.z;
    assign out_mode = emulation_function_select inside {3'h1, 3'h2, 3'h6, 3'h7};
    assign in_en = !(emulation_function_select inside {3'h1, 3'h2});
    property p_oe;
        resetn |=> emu_oe == $past(out_mode);
    endproperty
    a_oe: assert property (p_oe) else $error("oe wrong for mode");
    property p_quad;
        $past(resetn) && $past(emulation_direction_invert) == $past(emulation_direction_invert, 2)
            |-> !($changed(a) && $changed(b));
    endproperty
    a_quad: assert property (p_quad) else $error("a and b moved together");
    property p_pace;
        $past(resetn) && $past(emulation_direction_invert) == $past(emulation_direction_invert, 2)
            && ($changed(a) || $changed(b)) |=> ($stable(a) && $stable(b))[*3];
    endproperty
    a_pace: assert property (p_pace) else $error("edges too close");
    property p_index;
        $past(resetn) && emu_oe
            && $past(emulation_function_select) == $past(emulation_function_select, 2)
            && $past(emulation_lines_per_rev) == $past(emulation_lines_per_rev, 2)
            && $changed(z) |-> $changed(a) || $changed(b);
    endproperty
    a_index: assert property (p_index) else $error("index moved without count");
    property p_pulse;
        command_step |=> !command_step;
    endproperty
    a_pulse: assert property (p_pulse) else $error("step longer than one cycle");
    property p_hold;
        $past(resetn) && !command_step |-> $stable(command_position);
    endproperty
    a_hold: assert property (p_hold) else $error("command moved without step");
    property p_active;
        resetn |=> command_active == ($past(emulation_lines_per_rev) != 0 && $past(in_en));
    endproperty
    a_active: assert property (p_active) else $error("active level wrong");
    property p_zero;
        (emulation_lines_per_rev == 0)[*3] |=> !command_step;
    endproperty
    a_zero: assert property (p_zero) else $error("step with zero resolution");
    c_step: cover property (command_step);
    c_z: cover property (emu_oe && $rose(z));
    c_out: cover property (emu_oe && $changed(a));
    c_fmt: cover property (emulation_function_select == 3'h0 && secondary_input_format == 2'h1
        && command_step);
endmodule // emu_port_props

bind encoder_emulation_port emu_port_props #(.LPR_W(LPR_W)) i_emu_port_props (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .emulation_function_select(emulation_function_select),
    .emulation_lines_per_rev(emulation_lines_per_rev),
    .emulation_direction_invert(emulation_direction_invert),
    .secondary_input_format(secondary_input_format),
    .emulated_encoder_output(emulated_encoder_output),
    .emu_oe(emu_oe),
    .command_position(command_position),
    .command_step(command_step),
    .command_active(command_active)
);

`default_nettype wire

/* File: test/emu_far_ctrl.sv */
`default_nettype none

module emu_far_ctrl (
    input wire logic clk_sys,
    output logic pa,
    output logic pb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase = 2'h0;
    initial begin
        pa = 1'b0;
        pb = 1'b0;
    end
    task hold();
        repeat (4) @(posedge clk_sys);
    endtask
    task home();
        @(posedge clk_sys);
        phase = 2'h0;
        pa <= 1'b0;
        pb <= 1'b0;
    endtask
    task send(input logic [1:0] f, input logic up);
        @(posedge clk_sys);
        case (f)
            2'h0: begin
                phase = up ? phase + 2'h1 : phase - 2'h1;
                pa <= phase[0] ^ phase[1];
                pb <= phase[1];
            end
            2'h2: begin
                pa <= up;
                pb <= !up;
                hold();
                pa <= 1'b0;
                pb <= 1'b0;
            end
            default: begin
                pb <= up;
                hold();
                pa <= 1'b1;
                hold();
                pa <= 1'b0;
            end
        endcase
        hold();
    endtask
endmodule // emu_far_ctrl

`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys;
    logic resetn;
    logic [2:0] sel;
    logic [15:0] lpr;
    logic [15:0] zoff;
    logic [15:0] toff;
    logic inv;
    logic [1:0] fmt;
    logic [7:0] scale;
    emu_port_pkg::pos_t mpos;
    emu_port_pkg::pos_t foff;
    emu_port_pkg::cmd_t cpos;
    emu_port_pkg::quad_t eo;
    emu_port_pkg::quad_t eo_q;
    logic oe;
    logic cstep;
    logic cact;
    logic pa;
    logic pb;
    logic last_a;
    int n_ab = 0;
    int n_z = 0;
    int n_st = 0;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 11768;
    int l_o;
    int d;
    int z_ab;
    int ab0;
    encoder_emulation_port i_encoder_emulation_port (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .emulation_function_select(sel),
        .emulation_lines_per_rev(lpr),
        .index_fraction_offset(zoff),
        .absolute_turn_offset(toff),
        .emulation_direction_invert(inv),
        .secondary_input_format(fmt),
        .step_scale(scale),
        .motor_position(mpos),
        // Device output wins the wire while it drives
        .emu_a_in(oe ? eo.a : pa),
        .emu_b_in(oe ? eo.b : pb),
        .emulated_encoder_output(eo),
        .emu_oe(oe),
        .opto_step_in(pa),
        .opto_dir_in(pb),
        .full_offset(foff),
        .command_position(cpos),
        .command_step(cstep),
        .command_active(cact)
    );
    emu_far_ctrl i_emu_far_ctrl (.clk_sys(clk_sys), .pa(pa), .pb(pb));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        eo_q <= eo;
        if (eo.a !== eo_q.a || eo.b !== eo_q.b) begin
            n_ab <= n_ab + 1;
            last_a <= eo.a !== eo_q.a;
        end
        if (eo.z === 1'b1 && eo_q.z === 1'b0) begin
            n_z <= n_z + 1;
            z_ab <= n_ab + 1;
        end
        if (cstep === 1'b1) begin
            n_st <= n_st + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic emu_port_pkg::cmd_t next_cmd(emu_port_pkg::cmd_t c, logic up, int w,
            int l);
        int k;
        k = int'(c.count) + (up ? w : -w);
        if (k >= l) begin
            k -= l;
            c.turn++;
        end else if (k < 0) begin
            k += l;
            c.turn--;
        end
        c.count = 16'(k);
        return c;
    endfunction
    task automatic out_move(input logic [15:0] t, input logic [15:0] f, input int e, input int z);
        int a0;
        int z0;
        a0 = n_ab;
        z0 = n_z;
        @(posedge clk_sys);
        mpos <= {t, f};
        repeat (e * 4 + 12) @(posedge clk_sys);
        chk(n_ab - a0, e);
        chk(n_z - z0, z);
    endtask
    task automatic in_run(input logic [2:0] m, input logic [1:0] f, input logic [7:0] s,
            input logic [15:0] l, input int n);
        emu_port_pkg::cmd_t e;
        logic [1:0] pf;
        logic up;
        int w;
        int s0;
        int ok;
        int act;
        i_emu_far_ctrl.home();
        resetn <= 1'b0;
        sel <= m;
        fmt <= f;
        scale <= s;
        lpr <= l;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        pf = (m == 3'h3) ? 2'h0 : (m == 3'h5) ? 2'h2 : (m == 3'h0 && f != 2'h3) ? f : 2'h1;
        w = (pf != 2'h1 || s == 0) ? 1 : (s > l) ? int'(l) : int'(s);
        ok = l != 0 && !(m inside {3'h1, 3'h2}) && !(m == 3'h0 && f == 2'h3);
        act = l != 0 && !(m inside {3'h1, 3'h2});
        e = '0;
        s0 = n_st;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            up = 1'($random(seed));
            i_emu_far_ctrl.send(pf, up);
            if (ok != 0) e = next_cmd(e, up, w, l);
        end
        repeat (10) @(posedge clk_sys);
        chk(n_st - s0, ok != 0 ? n : 0);
        chk(cpos, e);
        chk(cact, act);
    endtask
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial begin
        resetn = 1'b0;
        sel = 3'h0;
        lpr = 16'h0010;
        zoff = 16'h4000 + 16'($random(seed) & 32'h7fff);
        toff = 16'h0000;
        inv = 1'b0;
        fmt = 2'h0;
        scale = 8'h00;
        mpos = '0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            @(posedge clk_sys);
            sel <= 3'(m);
            toff <= 16'($random(seed));
            repeat (3) @(posedge clk_sys);
            chk(oe, m inside {1, 2, 6, 7});
            chk(foff, {toff, zoff});
            chk(cact, !(m inside {1, 2}));
        end
        l_o = 4 * (2 + ($random(seed) & 7));
        d = (65536 + l_o - 1) / l_o;
        @(posedge clk_sys);
        sel <= 3'h1;
        lpr <= 16'(l_o);
        toff <= 16'h0002;
        ab0 = n_ab;
        out_move(16'h1, 16'h0, l_o, 1);
        chk(z_ab - ab0, (int'(zoff) * l_o) >> 16);
        out_move(16'h1, 16'(d), 1, 0);
        chk(last_a, 1'b1);
        out_move(16'h1, 16'h0, 1, 0);
        @(posedge clk_sys);
        inv <= 1'b1;
        out_move(16'h1, 16'(d), 1, 0);
        chk(last_a, 1'b0);
        out_move(16'h1, 16'h0, 1, 0);
        @(posedge clk_sys);
        inv <= 1'b0;
        sel <= 3'h2;
        out_move(16'h3, 16'h0, 2 * l_o, 1);
        in_run(3'h0, 2'h0, 8'h00, 16'h0010, 12);
        in_run(3'h0, 2'h1, 8'h03, 16'h0010, 12);
        in_run(3'h0, 2'h2, 8'h00, 16'h0010, 12);
        in_run(3'h0, 2'h3, 8'h00, 16'h0010, 6);
        in_run(3'h3, 2'h2, 8'h00, 16'h0020, 12);
        in_run(3'h4, 2'h0, 8'h14, 16'h0010, 12);
        in_run(3'h4, 2'h0, 8'h00, 16'h000c, 12);
        in_run(3'h5, 2'h0, 8'h00, 16'h0010, 12);
        in_run(3'h6, 2'h0, 8'h02, 16'h0010, 12);
        in_run(3'h7, 2'h0, 8'h00, 16'h0010, 12);
        in_run(3'h4, 2'h0, 8'h01, 16'h0000, 6);
        in_run(3'h2, 2'h0, 8'h00, 16'h0010, 4);
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
